// ===== sab_baud.sv
// baud divider producing a x16 sample tick and a bit tick
`default_nettype none
module sab_baud
   import sab_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // divisor and mode
   input wire logic [15:0] divisor,
   input wire logic run,
   // ticks out
   sab_tick_if.gen tk
);
   logic [15:0] cnt_reg;
   logic [3:0] sub_reg;
   // divider reloads on terminal count; a stopped divider restarts from zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         sub_reg <= 4'h0;
      end else if (ce) begin
         if (!run) begin
            cnt_reg <= 16'h0000;
            sub_reg <= 4'h0;
         end else if (cnt_reg >= divisor) begin
            cnt_reg <= 16'h0000;
            sub_reg <= sub_reg + 4'h1;
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end
   assign tk.tick16 = ce && run && (cnt_reg >= divisor);
   assign tk.tick1 = tk.tick16 && (sub_reg == 4'hf);
endmodule
`default_nettype wire

// ===== sab_pkg.sv
// package: register map, field positions, reset values and states of the serial block
`default_nettype none
package sab_pkg;
   localparam logic [2:0] SAB_OFF_RXSC = 3'h0;
   localparam logic [2:0] SAB_OFF_RXBUF = 3'h1;
   localparam logic [2:0] SAB_OFF_TXSC = 3'h2;
   localparam logic [2:0] SAB_OFF_TXBUF = 3'h3;
   localparam logic [2:0] SAB_OFF_BAUD = 3'h4;
   localparam logic [2:0] SAB_OFF_DIVH = 3'h5;
   localparam logic [2:0] SAB_OFF_DIVL = 3'h6;
   localparam logic [2:0] SAB_OFF_IRQ = 3'h7;
   // rx_status_control fields
   localparam int SAB_RX_SERIAL_PORT_ENABLE = 7;
   localparam int SAB_RX_NINE = 6;
   localparam int SAB_RX_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int SAB_RX_ADDRESS_DETECT_ENABLE = 3;
   localparam int SAB_RX_FRAMING_ERROR_FLAG = 2;
   localparam int SAB_RX_OVERRUN_ERROR_FLAG = 1;
   localparam int SAB_RX_D9 = 0;
   // tx_status_control fields
   localparam int SAB_TX_EN = 5;
   localparam int SAB_TX_SYNC = 4;
   localparam int SAB_TX_BRK = 3;
   localparam int SAB_TX_HIGH_SPEED_BAUD_SELECT = 2;
   localparam int SAB_TX_SHIFT_REGISTER_EMPTY = 1;
   // baud_control fields
   localparam int SAB_BC_IDLE = 6;
   localparam int SAB_BC_WIDE = 3;
   localparam int SAB_BC_WUE = 1;
   localparam int SAB_BC_ABD = 0;
   // irq control register fields
   localparam int SAB_IRQ_RECEIVE_IRQ_ENABLE = 0;
   localparam int SAB_IRQ_RECEIVE_IRQ_PRIORITY = 1;
   localparam int SAB_IRQ_GIE = 2;
   localparam int SAB_IRQ_RECEIVE_FLAG = 4;
   localparam int SAB_IRQ_TRANSMIT_BUFFER_EMPTY_FLAG = 5;
   localparam logic [7:0] SAB_RST_BYTE = 8'h00;
   localparam int SAB_BREAK_ZEROS = 12;
   localparam int SAB_OVS = 16;
   typedef enum {SAB_TX_IDLE, SAB_TX_START, SAB_TX_DATA, SAB_TX_STOP} sab_tx_state_t;
   typedef enum {SAB_RX_IDLE, SAB_RX_START, SAB_RX_DATA, SAB_RX_STOP} sab_rx_state_t;
endpackage
`default_nettype wire

// ===== sab_remote_node.sv
// partner: remote serial node driving the receive line, decoding the transmit line
`default_nettype none
module sab_remote_node
   import sab_pkg::*;
(
   // shared clock
   input wire logic clk,
   // lines seen from the remote side
   input wire logic tx_in,
   output var logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];
   int low_q[$];
   logic [7:0] d;
   int c;
   int lo;
   ////////////////////////////////////////
   // idle level of the line is high
   initial line_o = 1'b1;
   // level held for n clocks, changed just after an edge
   task automatic hold(input logic v, input int n);
      line_o <= v;
      repeat (n) @(posedge clk);
   endtask
   // lsb first, start low, stop high, one bit per sixteen clocks
   task automatic send(input logic [8:0] v, input int nb);
      hold(1'b0, SAB_OVS);
      for (int i = 0; i < nb; i++) begin
         hold(v[i], SAB_OVS);
      end
      hold(1'b1, SAB_OVS);
   endtask
   // mid-bit decoder; also logs the first low run so a break shows its length
   always begin
      @(negedge tx_in);
      c = 0;
      lo = 0;
      while (!(c >= 152 && tx_in)) begin
         @(posedge clk);
         c++;
         if (tx_in && lo == 0) lo = c;
         if (c % 16 == 8 && c > 8 && c < 144) d = {tx_in, d[7:1]};
      end
      got_q.push_back(d);
      low_q.push_back(lo);
   end
endmodule
`default_nettype wire

// ===== sab_tick_if.sv
// interface: baud tick pair from the divider to the serial engines
`default_nettype none
interface sab_tick_if;
   logic tick16;
   logic tick1;
   modport gen (output tick16, output tick1);
   modport use_ (input tick16, input tick1);
endinterface
`default_nettype wire

// ===== sab_top.sv
// serial port with address detect, edge wake-up and break transmission
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module sab_top
   import sab_pkg::*;
(
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   // register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // serial lines and sleep state
   input wire logic RX_LINE,
   input wire logic SLEEP,
   output logic TX_LINE,
   // interrupt request to the core
   output logic RX_IRQ,
   output logic RX_IRQ_HIGH
);
   sab_tick_if tk ();
   logic [7:0] rxsc_reg, txsc_reg, baud_reg, divh_reg, divl_reg, irq_reg;
   logic [7:0] rxbuf_reg, txbuf_reg;
   logic receive_flag_reg, transmit_buffer_empty_flag_reg, shift_register_empty_reg, framing_error_flag_reg, overrun_error_flag_reg, d9_reg, wue_reg;
   logic rx_q_reg, wake_low_reg, brk_clr;
   logic [7:0] rd_next;
   logic [15:0] divisor;
   logic port_on, rx_done, rx_keep, rx_framing_error_flag, tx_load;
   sab_tx_state_t tx_st_reg;
   sab_rx_state_t rx_st_reg;
   logic [8:0] tx_sh_reg, rx_sh_reg;
   logic [3:0] tx_cnt_reg, rx_cnt_reg, rx_ph_reg;
   logic tx_brk_reg, tx_pend_reg;
   logic rx_fall, brk_now;

   ////////////////////////////////////////////////////////////////////////////
   // baud divisor: x16 oversampling, clock stopped in sleep
   assign port_on = rxsc_reg[SAB_RX_SERIAL_PORT_ENABLE] && !txsc_reg[SAB_TX_SYNC];
   assign divisor = baud_reg[SAB_BC_WIDE] ? {divh_reg, divl_reg} : {8'h00, divl_reg};
   sab_baud u_baud (
      .clk(CLOCK),
      .rst_n(RSTN),
      .ce(CE && !SLEEP),
      .divisor(divisor),
      .run(port_on),
      .tk(tk)
   );
   // the divider sees no enable while asleep, so no byte is received

   ////////////////////////////////////////////////////////////////////////////
   // control registers written by software
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rxsc_reg <= SAB_RST_BYTE;
         txsc_reg <= SAB_RST_BYTE;
         baud_reg <= SAB_RST_BYTE;
         divh_reg <= SAB_RST_BYTE;
         divl_reg <= SAB_RST_BYTE;
         irq_reg <= SAB_RST_BYTE;
      end else if (CE) begin
         if (WR && ADDR == SAB_OFF_RXSC) begin
            rxsc_reg <= WDATA;
         end else if (WR && ADDR == SAB_OFF_TXSC) begin
            txsc_reg <= WDATA;
         end else if (WR && ADDR == SAB_OFF_BAUD) begin
            baud_reg <= WDATA;
         end else if (WR && ADDR == SAB_OFF_DIVH) begin
            divh_reg <= WDATA;
         end else if (WR && ADDR == SAB_OFF_DIVL) begin
            divl_reg <= WDATA;
         end else if (WR && ADDR == SAB_OFF_IRQ) begin
            irq_reg <= WDATA;
         end
         // hardware clear of break request wins over a same-cycle write
         if (brk_clr) begin
            txsc_reg[SAB_TX_BRK] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake enable: set by software, cleared by hardware on rising edge
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         wue_reg <= 1'b0;
         wake_low_reg <= 1'b0;
         rx_q_reg <= 1'b1;
      end else if (CE) begin
         rx_q_reg <= RX_LINE;
         if (!wue_reg) begin
            wake_low_reg <= 1'b0;
            if (WR && ADDR == SAB_OFF_BAUD) begin
               wue_reg <= WDATA[SAB_BC_WUE];
            end
         end else if (rx_fall) begin
            wake_low_reg <= 1'b1;
         end else if (wake_low_reg && RX_LINE && !rx_q_reg) begin
            wue_reg <= 1'b0;
            wake_low_reg <= 1'b0;
         end else if (WR && ADDR == SAB_OFF_BAUD && !WDATA[SAB_BC_WUE]) begin
            wue_reg <= 1'b0;
         end
      end
   end
   // edge seen from the registered line; runs without the baud clock, so sleep works
   assign rx_fall = wue_reg && !wake_low_reg && !RX_LINE && rx_q_reg;

   ////////////////////////////////////////////////////////////////////////////
   // transmitter: buffer, shift register, break framing
   assign tx_load = (tx_st_reg == SAB_TX_IDLE) && tx_pend_reg && txsc_reg[SAB_TX_EN];
   // request still reads set in the cycle its clear lands; preloaded byte must not break again
   assign brk_now = txsc_reg[SAB_TX_BRK] && !brk_clr;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         txbuf_reg <= SAB_RST_BYTE;
         tx_pend_reg <= 1'b0;
      end else if (CE) begin
         if (WR && ADDR == SAB_OFF_TXBUF) begin
            txbuf_reg <= WDATA;
            tx_pend_reg <= 1'b1;
         end else if (tx_load) begin
            tx_pend_reg <= 1'b0;
         end
      end
   end
   // buffer-empty flag follows the pending byte, so preload during a break works
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         transmit_buffer_empty_flag_reg <= 1'b1;
      end else if (CE) begin
         if (WR && ADDR == SAB_OFF_TXBUF) begin
            transmit_buffer_empty_flag_reg <= 1'b0;
         end else if (tx_load || !tx_pend_reg) begin
            transmit_buffer_empty_flag_reg <= 1'b1;
         end
      end
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         tx_st_reg <= SAB_TX_IDLE;
         tx_sh_reg <= 9'h1ff;
         tx_cnt_reg <= 4'h0;
         tx_brk_reg <= 1'b0;
         shift_register_empty_reg <= 1'b1;
         TX_LINE <= 1'b1;
         brk_clr <= 1'b0;
      end else if (CE) begin
         brk_clr <= 1'b0;
         case (tx_st_reg)
            SAB_TX_IDLE: begin
               TX_LINE <= 1'b1;
               if (tx_load) begin
                  tx_brk_reg <= brk_now;
                  // break ignores the written byte and shifts zeros
                  tx_sh_reg <= brk_now ? 9'h000 : {1'b1, txbuf_reg};
                  shift_register_empty_reg <= 1'b0;
                  tx_st_reg <= SAB_TX_START;
               end
            end
            SAB_TX_START: begin
               if (tk.tick1) begin
                  TX_LINE <= 1'b0;
                  tx_cnt_reg <= 4'h0;
                  tx_st_reg <= SAB_TX_DATA;
               end
            end
            SAB_TX_DATA: begin
               if (tk.tick1) begin
                  TX_LINE <= tx_brk_reg ? 1'b0 : tx_sh_reg[0];
                  tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
                  tx_cnt_reg <= tx_cnt_reg + 4'h1;
                  // twelve zero bits for a break, eight data bits otherwise
                  if (tx_cnt_reg == (tx_brk_reg ? 4'(SAB_BREAK_ZEROS - 1) : 4'h7)) begin
                     tx_st_reg <= SAB_TX_STOP;
                  end
               end
            end
            SAB_TX_STOP: begin
               if (tk.tick1 && TX_LINE == 1'b0) begin
                  TX_LINE <= 1'b1;
               end else if (tk.tick1) begin
                  brk_clr <= tx_brk_reg;
                  tx_brk_reg <= 1'b0;
                  shift_register_empty_reg <= 1'b1;
                  tx_st_reg <= SAB_TX_IDLE;
               end
            end
            default: tx_st_reg <= SAB_TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver: x16 sampling at mid-bit, idle while wake enable is set
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rx_st_reg <= SAB_RX_IDLE;
         rx_sh_reg <= 9'h000;
         rx_cnt_reg <= 4'h0;
         rx_ph_reg <= 4'h0;
      end else if (CE) begin
         if (wue_reg || !rxsc_reg[SAB_RX_CONTINUOUS_RECEIVE_ENABLE] || !port_on) begin
            rx_st_reg <= SAB_RX_IDLE;
         end else if (tk.tick16) begin
            rx_ph_reg <= rx_ph_reg + 4'h1;
            case (rx_st_reg)
               SAB_RX_IDLE: begin
                  rx_ph_reg <= 4'h0;
                  if (!RX_LINE) begin
                     rx_st_reg <= SAB_RX_START;
                  end
               end
               SAB_RX_START: begin
                  if (rx_ph_reg == 4'(SAB_OVS / 2 - 1)) begin
                     rx_ph_reg <= 4'h0;
                     rx_cnt_reg <= 4'h0;
                     rx_st_reg <= RX_LINE ? SAB_RX_IDLE : SAB_RX_DATA;
                  end
               end
               SAB_RX_DATA: begin
                  if (rx_ph_reg == 4'(SAB_OVS - 1)) begin
                     rx_sh_reg <= {RX_LINE, rx_sh_reg[8:1]};
                     rx_cnt_reg <= rx_cnt_reg + 4'h1;
                     if (rx_cnt_reg == (rxsc_reg[SAB_RX_NINE] ? 4'h8 : 4'h7)) begin
                        rx_st_reg <= SAB_RX_STOP;
                     end
                  end
               end
               SAB_RX_STOP: begin
                  if (rx_ph_reg == 4'(SAB_OVS - 1)) begin
                     rx_st_reg <= SAB_RX_IDLE;
                  end
               end
               default: rx_st_reg <= SAB_RX_IDLE;
            endcase
         end
      end
   end
   assign rx_done = tk.tick16 && (rx_st_reg == SAB_RX_STOP) && (rx_ph_reg == 4'(SAB_OVS - 1))
      && !wue_reg && rxsc_reg[SAB_RX_CONTINUOUS_RECEIVE_ENABLE];
   assign rx_framing_error_flag = !RX_LINE;
   // in detect mode with nine-bit frames only frames with ninth bit one are kept
   assign rx_keep = !(rxsc_reg[SAB_RX_ADDRESS_DETECT_ENABLE] && rxsc_reg[SAB_RX_NINE]) || rx_sh_reg[8];

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer, errors and ninth bit
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rxbuf_reg <= SAB_RST_BYTE;
         d9_reg <= 1'b0;
         framing_error_flag_reg <= 1'b0;
         overrun_error_flag_reg <= 1'b0;
      end else if (CE) begin
         if (rx_done && rx_keep && receive_flag_reg) begin
            overrun_error_flag_reg <= 1'b1;
         end else if (rx_done && rx_keep) begin
            rxbuf_reg <= rxsc_reg[SAB_RX_NINE] ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
            d9_reg <= rxsc_reg[SAB_RX_NINE] & rx_sh_reg[8];
            framing_error_flag_reg <= rx_framing_error_flag;
         end else if (!rxsc_reg[SAB_RX_CONTINUOUS_RECEIVE_ENABLE]) begin
            framing_error_flag_reg <= 1'b0;
            overrun_error_flag_reg <= 1'b0;
         end
      end
   end
   // receive flag: set wins over the clear by a buffer read
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         receive_flag_reg <= 1'b0;
      end else if (CE) begin
         if ((rx_done && rx_keep && !receive_flag_reg) || rx_fall) begin
            receive_flag_reg <= 1'b1;
         end else if (RD && ADDR == SAB_OFF_RXBUF) begin
            receive_flag_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt line and priority select
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RX_IRQ <= 1'b0;
         RX_IRQ_HIGH <= 1'b0;
      end else if (CE) begin
         RX_IRQ <= receive_flag_reg && irq_reg[SAB_IRQ_RECEIVE_IRQ_ENABLE] && irq_reg[SAB_IRQ_GIE];
         RX_IRQ_HIGH <= irq_reg[SAB_IRQ_RECEIVE_IRQ_PRIORITY];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, data one cycle after the strobe
   always_comb begin
      rd_next = 8'h00;
      if (ADDR == SAB_OFF_RXSC) begin
         rd_next = {rxsc_reg[7:3], framing_error_flag_reg, overrun_error_flag_reg, d9_reg};
      end else if (ADDR == SAB_OFF_RXBUF) begin
         rd_next = rxbuf_reg;
      end else if (ADDR == SAB_OFF_TXSC) begin
         rd_next = {txsc_reg[7:2], shift_register_empty_reg, txsc_reg[0]};
      end else if (ADDR == SAB_OFF_BAUD) begin
         rd_next = {1'b0, rx_st_reg == SAB_RX_IDLE, 1'b0, baud_reg[4:2], wue_reg,
            baud_reg[0]};
      end else if (ADDR == SAB_OFF_DIVH) begin
         rd_next = divh_reg;
      end else if (ADDR == SAB_OFF_DIVL) begin
         rd_next = divl_reg;
      end else if (ADDR == SAB_OFF_IRQ) begin
         rd_next = {2'b00, transmit_buffer_empty_flag_reg, receive_flag_reg, 1'b0, irq_reg[2:0]};
      end
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= 8'h00;
      end else if (CE) begin
         RDATA <= RD ? rd_next : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== sab_top_assertions.sv
// checker: port-level properties of the serial block
`default_nettype none
module sab_chk
   import sab_pkg::*;
(
   // clock, reset and register port
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // lines and interrupt
   input wire logic RX_LINE,
   input wire logic SLEEP,
   input wire logic TX_LINE,
   input wire logic RX_IRQ,
   input wire logic RX_IRQ_HIGH
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   logic [7:0] div_reg;
   logic [15:0] low_reg;
   logic txw_reg;
   ////////////////////////////////////////
   // divisor mirror sizes the longest legal low run on the line
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) div_reg <= 8'h00;
      else if (CE && WR && ADDR == SAB_OFF_DIVL) div_reg <= WDATA;
   end
   // low run length; 16 bits hold the longest break at a one-byte divisor (13 x 16 x 256 clocks)
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) low_reg <= 16'h0000;
      else if (TX_LINE) low_reg <= 16'h0000;
      else low_reg <= low_reg + 16'h0001;
   end
   // set by the first byte handed to the transmitter
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) txw_reg <= 1'b0;
      else if (CE && WR && ADDR == SAB_OFF_TXBUF) txw_reg <= 1'b1;
   end
   ////////////////////////////////////////
   // properties
   chk_reset_rest: assert property (disable iff (1'b0)
      !RSTN |-> TX_LINE && RDATA == 8'h00 && !RX_IRQ && !RX_IRQ_HIGH)
      else $error("outputs not at rest during reset");
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside read answer");
   chk_txbuf_zero: assert property ($past(RD) && $past(ADDR) == SAB_OFF_TXBUF |-> RDATA == 8'h00)
      else $error("transmit buffer read not zero");
   chk_irq_mirror: assert property ($past(RD) && $past(ADDR) == SAB_OFF_IRQ |->
      RX_IRQ == (RDATA[SAB_IRQ_RECEIVE_FLAG] && RDATA[SAB_IRQ_RECEIVE_IRQ_ENABLE] && RDATA[SAB_IRQ_GIE])
      && RX_IRQ_HIGH == RDATA[SAB_IRQ_RECEIVE_IRQ_PRIORITY])
      else $error("irq outputs disagree with irq register");
   chk_prio_copy: assert property (CE && WR && ADDR == SAB_OFF_IRQ |->
      ##2 RX_IRQ_HIGH == $past(WDATA[SAB_IRQ_RECEIVE_IRQ_PRIORITY], 2))
      else $error("priority output not following write");
   chk_read_clears: assert property (CE && RD && ADDR == SAB_OFF_RXBUF && RX_IRQ
      |-> ##[1:2] !RX_IRQ)
      else $error("buffer read left irq up");
   chk_tx_idle: assert property (!txw_reg |-> TX_LINE)
      else $error("transmit line left idle level");
   chk_break_bound: assert property (int'(low_reg) <=
      (SAB_BREAK_ZEROS + 1) * SAB_OVS * (int'(div_reg) + 1) + 2)
      else $error("transmit low run too long");
   // main scenarios reached
   cov_read_irq: cover property (RD && ADDR == SAB_OFF_RXBUF && RX_IRQ);
   cov_prio: cover property ($rose(RX_IRQ_HIGH));
   cov_break: cover property (low_reg > 16'h00C0);
endmodule
bind sab_top sab_chk chk_u (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .RX_LINE(RX_LINE), .SLEEP(SLEEP), .TX_LINE(TX_LINE),
   .RX_IRQ(RX_IRQ), .RX_IRQ_HIGH(RX_IRQ_HIGH));
`default_nettype wire

// ===== testbench.sv
// testbench: register-level scenarios for the serial block
`default_nettype none
module testbench
   import sab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK;
   logic RSTN = 1'b1;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic SLEEP = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic RX_LINE, TX_LINE, RX_IRQ, RX_IRQ_HIGH;
   logic [7:0] RDATA, v;
   int fails, n_checks, cyc;
   ////////////////////////////////////////
   // device and remote node; clock enable tied on
   sab_top dut_u (.CLOCK(CLOCK), .RSTN(RSTN), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .RX_LINE(RX_LINE), .SLEEP(SLEEP),
      .TX_LINE(TX_LINE), .RX_IRQ(RX_IRQ), .RX_IRQ_HIGH(RX_IRQ_HIGH));
   sab_remote_node pn_u (.clk(CLOCK), .tx_in(TX_LINE), .line_o(RX_LINE));
   // 20 MHz clock
   initial begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end
   // hang guard, far above the roughly 4100 cycles of the run
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         $display("CHECK FAILED at %0t: timeout", $time);
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] dt);
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= dt;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   // answer stands only in the cycle after the strobe
   task automatic rdchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
      input string what);
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 v = RDATA;
      chk(v & m, e, what);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rdchk(SAB_OFF_RXSC, 8'hFF, 8'h00, "rx status reset");
      rdchk(SAB_OFF_TXSC, 8'hFF, 8'h02, "tx status reset");
      rdchk(SAB_OFF_IRQ, 8'hFF, 8'h20, "irq reset");
      rdchk(SAB_OFF_TXBUF, 8'hFF, 8'h00, "tx buffer reads zero");
      $display("test reset done");
   endtask
   task automatic t_addr();
      wr(SAB_OFF_DIVL, 8'h00);
      wr(SAB_OFF_TXSC, 8'h00);
      wr(SAB_OFF_RXSC, 8'h80);
      wr(SAB_OFF_IRQ, 8'h07);
      wr(SAB_OFF_RXSC, 8'hC0);
      wr(SAB_OFF_RXSC, 8'hC8);
      wr(SAB_OFF_RXSC, 8'hD8);
      pn_u.send(9'h012, 9);
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h00, "data frame dropped");
      pn_u.send(9'h134, 9);
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h10, "address flagged");
      chk({6'h00, RX_IRQ_HIGH, RX_IRQ}, 8'h03, "irq and priority");
      rdchk(SAB_OFF_RXSC, 8'h01, 8'h01, "ninth bit");
      rdchk(SAB_OFF_RXBUF, 8'hFF, 8'h34, "address byte");
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h00, "flag cleared by read");
      wr(SAB_OFF_RXSC, 8'hD0);
      pn_u.send(9'h056, 9);
      rdchk(SAB_OFF_RXSC, 8'h01, 8'h00, "ninth bit zero");
      rdchk(SAB_OFF_RXBUF, 8'hFF, 8'h56, "data kept");
      pn_u.send(9'h0A1, 9);
      pn_u.send(9'h0A2, 9);
      rdchk(SAB_OFF_RXSC, 8'h02, 8'h02, "overrun");
      rdchk(SAB_OFF_RXBUF, 8'hFF, 8'hA1, "not overwritten");
      wr(SAB_OFF_RXSC, 8'hC0);
      rdchk(SAB_OFF_RXSC, 8'h06, 8'h00, "errors cleared");
      $display("test address detect done");
   endtask
   task automatic t_wake();
      wr(SAB_OFF_RXSC, 8'h90);
      wr(SAB_OFF_IRQ, 8'h01);
      rdchk(SAB_OFF_BAUD, 8'h40, 8'h40, "receiver idle");
      wr(SAB_OFF_BAUD, 8'h02);
      @(posedge CLOCK);
      SLEEP <= 1'b1;
      pn_u.hold(1'b0, 3);
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h10, "wake flag");
      chk({7'h00, RX_IRQ}, 8'h00, "irq masked");
      pn_u.hold(1'b0, 200);
      rdchk(SAB_OFF_BAUD, 8'h02, 8'h02, "still waiting");
      rdchk(SAB_OFF_RXSC, 8'h04, 8'h00, "no framing error");
      pn_u.hold(1'b1, 16);
      rdchk(SAB_OFF_BAUD, 8'h02, 8'h00, "wake cleared");
      @(posedge CLOCK);
      SLEEP <= 1'b0;
      rdchk(SAB_OFF_RXBUF, 8'h00, 8'h00, "dummy byte");
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h00, "flag cleared by read");
      pn_u.send(9'h03C, 8);
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h10, "second flag");
      rdchk(SAB_OFF_RXBUF, 8'hFF, 8'h3C, "byte after wake");
      $display("test wake done");
   endtask
   // remote break at 144 clocks a bit, received at 208: the 9/13 ratio puts the stop
   // transition ahead of the stop sample, so the break reads as a clean zero byte
   task automatic t_brk_rx();
      wr(SAB_OFF_DIVH, 8'h01);
      wr(SAB_OFF_DIVL, 8'h0C);
      rdchk(SAB_OFF_DIVH, 8'hFF, 8'h01, "divisor high stored");
      pn_u.hold(1'b0, 1872);
      pn_u.hold(1'b1, 416);
      rdchk(SAB_OFF_RXSC, 8'h06, 8'h00, "break no error");
      rdchk(SAB_OFF_IRQ, 8'h10, 8'h10, "break received");
      rdchk(SAB_OFF_RXBUF, 8'hFF, 8'h00, "break reads zero");
      wr(SAB_OFF_DIVL, 8'h00);
      $display("test break receive done");
   endtask
   task automatic t_break();
      wr(SAB_OFF_IRQ, 8'h00);
      wr(SAB_OFF_TXSC, 8'h28);
      wr(SAB_OFF_TXBUF, 8'hAA);
      rdchk(SAB_OFF_IRQ, 8'h20, 8'h20, "buffer empty");
      wr(SAB_OFF_TXBUF, 8'h55);
      rdchk(SAB_OFF_TXSC, 8'h0A, 8'h08, "break busy");
      repeat (600) if (pn_u.got_q.size() < 2) @(posedge CLOCK);
      repeat (20) @(posedge CLOCK);
      chk(8'(pn_u.got_q.size()), 8'h02, "frames seen");
      chk(pn_u.got_q[0], 8'h00, "break zeros");
      chk(8'((pn_u.low_q[0] + 8) / SAB_OVS), 8'h0D, "break length");
      chk(pn_u.got_q[1], 8'h55, "sync byte");
      rdchk(SAB_OFF_TXSC, 8'h0A, 8'h02, "break done");
      wr(SAB_OFF_BAUD, 8'h01);
      rdchk(SAB_OFF_BAUD, 8'h01, 8'h01, "auto baud stored");
      $display("test break done");
   endtask
   task automatic close_out();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // reset for twelve cycles, then the scenarios; a real falling edge at time zero
   // puts every flop in its reset state before the first clock edge
   initial begin
      RSTN <= 1'b0;
      repeat (12) @(posedge CLOCK);
      RSTN <= 1'b1;
      t_reset();
      t_addr();
      t_wake();
      t_brk_rx();
      t_break();
      close_out();
   end
endmodule
`default_nettype wire
